// ### tb.sv
`timescale 1ns/1ns
module tb
  import uft_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic [2:0] regAddr;
  logic [7:0] regWdata;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regRdata;
  logic       rxPin;
  logic       txPin;
  logic       txPinOe;
  logic       txIrq;
  logic       rxIrq;
  logic       txLine;
  int         fails;
  int         tests_run;
  int         irqs;

  // Released pin floats high through the line pull-up
  assign txLine = txPinOe ? txPin : 1'b1;

  uft_core dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .rxPin(rxPin), .txPin(txPin),
    .txPinOe(txPinOe), .txIrq(txIrq), .rxIrq(rxIrq));
  uft_peer peer (.clk(clk), .txLine(txLine), .rxLine(rxPin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) if (rxIrq === 1'b1) irqs++;

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    d = regRdata;
    @(posedge clk);
  endtask

  task automatic tx_get(input int n, input int bc, output logic [31:0] b);
    bit ok;
    peer.grab(n, bc, b, ok);
    if (!ok) begin
      fails++;
      wrap_up();
    end
  endtask

  // Expected line bits, start bit at index 0
  function automatic logic [31:0] fr(input logic [8:0] w, input int nb,
                                     input logic pe, input logic od,
                                     input int ns);
    logic [31:0] b;
    logic        p;
    b = '0;
    p = od;
    for (int i = 0; i < nb; i++) b[i + 1] = w[i];
    for (int i = 0; i < nb - 1; i++) p ^= w[i];
    if (pe) b[nb] = p;
    for (int i = 0; i < ns; i++) b[nb + 1 + i] = 1'b1;
    return b;
  endfunction

  task automatic reset_case();
    logic [7:0] s;
    check({txPinOe, txPin}, 2'b01);
    rd(ADDR_STATUS, s);
    check(s, 8'h0b);
    rd(3'h5, s);
    check(s, 8'h00);
  endtask

  // Direct load, held word, ignored third write, then idle
  task automatic tx_case(input logic [7:0] c1, input logic [7:0] c2,
                         input logic [7:0] bd, input int bc);
    logic [7:0]  s;
    logic [31:0] got;
    logic [31:0] exp;
    int          nb;
    int          ns;
    int          ln;
    nb = c1[C1_NINE] ? 9 : 8;
    ns = c1[C1_TWOSTOP] ? 2 : 1;
    ln = 1 + nb + ns;
    wr(ADDR_BAUD, bd);
    wr(ADDR_CTRL1, c1);
    wr(ADDR_CTRL2, c2);
    fork
      tx_get(2 * ln + 1, bc, got);
      begin
        rd(ADDR_STATUS, s);
        wr(ADDR_DATA, 8'ha5);
        rd(ADDR_STATUS, s);
        check(s[0], 1'b1);
        wr(ADDR_DATA, 8'h3c);
        rd(ADDR_STATUS, s);
        check(s[1:0], 2'h0);
        wr(ADDR_DATA, 8'hff);
      end
    join
    exp = fr({c1[C1_TX8], 8'ha5}, nb, c1[C1_PAREN], c1[C1_ODD], ns);
    exp |= fr({c1[C1_TX8], 8'h3c}, nb, c1[C1_PAREN], c1[C1_ODD], ns) << ln;
    exp |= 32'h1 << (2 * ln);
    check(got, exp);
    rd(ADDR_STATUS, s);
    check(s[1:0], 2'h3);
    check(txIrq, c2[C2_TXIE]);
  endtask

  task automatic rx_case();
    logic [7:0] s;
    logic [7:0] d;
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_CTRL1, 8'hc0);
    wr(ADDR_CTRL2, 8'he8);
    peer.send(fr(9'h15a, 9, 1'b0, 1'b0, 1), 11);
    rd(ADDR_CTRL1, d);
    check(d[C1_RX8], 1'b1);
    rd(ADDR_STATUS, s);
    check(s[2], 1'b1);
    rd(ADDR_DATA, d);
    check(d, 8'h5a);
    rd(ADDR_STATUS, s);
    check(s[2], 1'b0);
    check(irqs, 1);
  endtask

  // Parity error, overrun, framing error, then turn off
  task automatic err_case();
    logic [7:0] s;
    logic [7:0] d;
    wr(ADDR_CTRL1, 8'hb0);
    peer.send(fr(9'h031, 8, 1'b1, 1'b1, 1), 10);
    peer.send(fr(9'h032, 8, 1'b1, 1'b0, 1), 10);
    peer.send(fr(9'h033, 8, 1'b1, 1'b1, 1), 10);
    rd(ADDR_STATUS, s);
    check({s[7], s[4]}, 2'h3);
    rd(ADDR_DATA, d);
    check(d[6:0], 7'h31);
    rd(ADDR_DATA, d);
    check(d[6:0], 7'h32);
    rd(ADDR_STATUS, s);
    check(s[7:2], 6'h02);
    peer.send(fr(9'h055, 8, 1'b1, 1'b1, 0), 10);
    rd(ADDR_STATUS, s);
    check(s[5], 1'b1);
    check(irqs, 5);
    wr(ADDR_CTRL1, 8'h30);
    rd(ADDR_STATUS, s);
    check(s, 8'h0b);
    rd(ADDR_CTRL2, d);
    check(d & 8'hd0, 8'h00);
  endtask

  // Word written before enable waits, then goes out
  task automatic pre_case();
    logic [7:0]  s;
    logic [31:0] got;
    wr(ADDR_CTRL1, 8'h80);
    wr(ADDR_CTRL2, 8'h20);
    wr(ADDR_DATA, 8'h96);
    repeat (40) @(posedge clk);
    check({txPinOe, txPin}, 2'b01);
    rd(ADDR_STATUS, s);
    check(s[0], 1'b0);
    wr(ADDR_CTRL2, 8'ha0);
    tx_get(10, 16, got);
    check(got, fr(9'h096, 8, 1'b0, 1'b0, 1));
  endtask

  task automatic brk_case();
    logic [7:0]  s;
    logic [31:0] got;
    wr(ADDR_CTRL1, 8'h80);
    wr(ADDR_CTRL2, 8'ha0);
    wr(ADDR_DATA, 8'h00);
    repeat (40) @(posedge clk);
    wr(ADDR_CTRL2, 8'h20);
    @(posedge clk);
    @(negedge clk);
    check({txPinOe, txPin}, 2'b01);
    rd(ADDR_STATUS, s);
    check(s[1:0], 2'h3);
    fork
      tx_get(30, 16, got);
      begin
        wr(ADDR_CTRL2, 8'hb0);
        repeat (320) @(posedge clk);
        wr(ADDR_CTRL2, 8'ha0);
      end
    join
    check(got, 32'h38000000);
    rd(ADDR_STATUS, s);
    check(s[1:0], 2'h3);
  endtask

  initial begin
    rst_n = 1'b0;
    regAddr = '0;
    regWdata = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    fails = 0;
    tests_run = 0;
    irqs = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reset_case();
    tx_case(8'h80, 8'ha1, 8'h00, 16);
    tx_case(8'hf9, 8'ha0, 8'h01, 32);
    tx_case(8'ha8, 8'h80, 8'h00, 64);
    rx_case();
    err_case();
    pre_case();
    brk_case();
    wrap_up();
  end
endmodule

// ### uft_core.sv
// How it works
// [R1] Nine-bit words when selected; ninth bit comes from tx_bit_eight.
// [R2] Received ninth bit shows in rx_bit_eight, apart from the data byte.
// [R3] Parity enable switches parity; parity select picks odd or even.
// [R4] Two stop bits only on transmit; receiver checks one stop bit.
// [R5] With parity off, word MSB is carried as the address bit unchanged.
// [R6] Shifter reloads from buffer only after previous stop bits end.
// [R7] Sending starts once enabled and data written, either order.
// [R8] Clearing transmit enable aborts frame, resets transmitter, releases pin.
// [R9] Frames go out least significant bit first.
// [R10] Data writes are ignored while tx_empty_flag is low.
// [R11] Status read then data write clears tx_idle_flag; tx_empty_flag clears only when the word is held.
// [R12] tx_empty_flag set when buffer free; gated interrupt request.
// [R13] Write when idle loads shifter directly; else held until frame ends.
// [R14] tx_idle_flag set after stop bits or after a break frame.
// [R15] Break armed after control held over divisor+1 clocks while idle.
// [R16] Break is start then 13-bit zero groups, repeating while held.
// [R17] After break clears, finish group then stop bits; no tx interrupt.
// [R18] Receiver samples at sixteen times the bit rate.
// [R19] Each received bit decided by three-sample majority.
// [R20] Two words buffered; third word lost on overflow, overrun set.
// [R21] rx_avail_flag when buffered; interrupt on each shifter transfer.
// [R22] Status read then data read acknowledges received data.
// [R23] Receiver hunts start bit when enabled; sets error flags.
// [R24] Bit rate is clock over 64(N+1), or 16(N+1) in high speed.
// [R25] Transmit pin rests high when nothing is sent.
// [R26] Turning off empties buffers, clears tx/rx enables, break and flags, sets idles.
// [R27] Zero sampled at stop position sets framing_flag.
// [R28] Parity replaces the top data position, computed over the rest.
// [R29] Received parity mismatch sets the parity error flag.
`timescale 1ns/1ns
module uft_core
  import uft_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  // Serial line
  input  wire logic       rxPin,
  output logic            txPin,
  output logic            txPinOe,
  // Interrupt requests
  output logic            txIrq,
  output logic            rxIrq
);

  logic [7:0] ctrl1Reg, ctrl2Reg, baudReg, rdataReg;
  logic statusSeenReg;
  logic [7:0] divCnt;
  logic [1:0] preCnt;
  logic sampleTick, divWrap;
  logic uartOn, nine, parEn, parOdd, twoStop;
  logic txRun, rxRun, brkCtrl;
  logic dataWr, dataRd;
  logic [3:0] nBits;

  assign uartOn  = ctrl1Reg[C1_ON];
  assign nine    = ctrl1Reg[C1_NINE];
  assign parEn   = ctrl1Reg[C1_PAREN];
  assign parOdd  = ctrl1Reg[C1_ODD];
  assign twoStop = ctrl1Reg[C1_TWOSTOP];
  assign txRun   = uartOn & ctrl2Reg[C2_TXEN];
  assign rxRun   = uartOn & ctrl2Reg[C2_RXEN];
  assign brkCtrl = ctrl2Reg[C2_BRK];
  assign dataWr  = regWrite && regAddr == ADDR_DATA;
  assign dataRd  = regRead && regAddr == ADDR_DATA;
  assign nBits   = nine ? BITS_NINE : BITS_EIGHT; // R1

  // Parity placed in top position, MSB otherwise kept as is
  function automatic logic [8:0] frameWord(input logic [8:0] w,
      input logic nn, input logic pe, input logic odd);
    logic [8:0] r;
    r = w; // R5
    if (nn) begin
      if (pe) r[8] = ^w[7:0] ^ odd; // R28 R3
    end else begin
      r[8] = 1'b0;
      if (pe) r[7] = ^w[6:0] ^ odd; // R28 R3
    end
    return r;
  endfunction

  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1Reg <= CTRL1_RST;
      baudReg  <= BAUD_RST;
    end else if (regWrite) begin
      if (regAddr == ADDR_CTRL1) ctrl1Reg <= regWdata;
      if (regAddr == ADDR_BAUD) baudReg <= regWdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl2Reg <= CTRL2_RST;
    end else begin
      if (regWrite && regAddr == ADDR_CTRL2) ctrl2Reg <= regWdata;
      if (!uartOn) begin
        ctrl2Reg[C2_TXEN] <= 1'b0; // R26
        ctrl2Reg[C2_RXEN] <= 1'b0;
        ctrl2Reg[C2_BRK]  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) statusSeenReg <= 1'b0;
    else if (regRead && regAddr == ADDR_STATUS) statusSeenReg <= 1'b1;
    else if (dataWr || dataRd) statusSeenReg <= 1'b0;
  end

  // Baud generator: oversample tick every (N+1) or 4(N+1) clocks
  assign divWrap = uartOn && divCnt == baudReg;
  assign sampleTick = divWrap && (ctrl2Reg[C2_HS] ||
                                  preCnt == LOW_PRESCALE); // R24 R18

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt <= 8'h00;
      preCnt <= 2'h0;
    end else if (!uartOn) begin
      divCnt <= 8'h00;
      preCnt <= 2'h0;
    end else if (divWrap) begin
      divCnt <= 8'h00;
      preCnt <= preCnt + 2'h1;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  // Transmitter
  uft_tx_state_t txState;
  uft_word_t txBuf;
  logic txBufFull, txEmptyFlag, txIdleFlag;
  logic [8:0] txShift;
  logic [3:0] txBitCnt, txPhase;
  logic txStopCnt, brkMode, brkArmed, bitTick;
  logic txLoadDirect, txFromBuf, txFrameDone;
  logic [9:0] brkCnt;

  assign txEmptyFlag  = !txBufFull; // R12
  assign bitTick      = sampleTick && txPhase == LAST_PHASE;
  assign txLoadDirect = dataWr && txEmptyFlag && txState == TX_IDLE &&
                        txRun && !brkArmed; // R13
  assign txFromBuf    = txState == TX_IDLE && txRun && txBufFull &&
                        !brkArmed; // R6 R7
  assign txFrameDone  = txState == TX_STOP && bitTick &&
                        (!twoStop || txStopCnt); // R4
  assign brkArmed = brkCnt > {2'b00, baudReg} + 10'h001; // R15
  assign txPinOe  = txRun; // R8
  assign txIrq    = ctrl2Reg[C2_TXIE] & txEmptyFlag; // R12 R17

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBufFull <= 1'b0;
      txBuf     <= '0;
    end else if (!uartOn) begin
      txBufFull <= 1'b0; // R26
    end else if (dataWr && txEmptyFlag && !txLoadDirect) begin // R10
      txBuf     <= {ctrl1Reg[C1_TX8], regWdata}; // R1
      txBufFull <= 1'b1; // R13
    end else if (txFromBuf) begin
      txBufFull <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) brkCnt <= 10'h000;
    else if (!brkCtrl || !txIdleFlag || txState != TX_IDLE)
      brkCnt <= 10'h000;
    else if (!brkArmed) brkCnt <= brkCnt + 10'h001; // R15
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState   <= TX_IDLE;
      txPin     <= 1'b1;
      txShift   <= 9'h000;
      txBitCnt  <= 4'h0;
      txPhase   <= 4'h0;
      txStopCnt <= 1'b0;
      brkMode   <= 1'b0;
    end else if (!txRun) begin
      txState <= TX_IDLE; // R8
      txPin   <= 1'b1;
      txPhase <= 4'h0;
      brkMode <= 1'b0;
    end else begin
      if (sampleTick && txState != TX_IDLE) txPhase <= txPhase + 4'h1;
      unique case (txState)
        TX_IDLE: begin
          txPin   <= 1'b1; // R25
          txPhase <= 4'h0;
          if (brkArmed) begin
            txState <= TX_START; // R16
            txPin   <= 1'b0;
            brkMode <= 1'b1;
          end else if (txLoadDirect || txFromBuf) begin
            txShift <= frameWord(txLoadDirect ?
                         {ctrl1Reg[C1_TX8], regWdata} : txBuf,
                         nine, parEn, parOdd);
            txState <= TX_START;
            txPin   <= 1'b0;
            brkMode <= 1'b0;
          end
        end
        TX_START: if (bitTick) begin
          txBitCnt <= 4'h0;
          if (brkMode) begin
            txState <= TX_BREAK;
          end else begin
            txState  <= TX_DATA;
            txPin    <= txShift[0]; // R9
            txShift  <= {1'b0, txShift[8:1]};
            txBitCnt <= 4'h1;
          end
        end
        TX_DATA: if (bitTick) begin
          if (txBitCnt == nBits) begin
            txState   <= TX_STOP;
            txPin     <= 1'b1;
            txStopCnt <= 1'b0;
          end else begin
            txPin    <= txShift[0]; // R9
            txShift  <= {1'b0, txShift[8:1]};
            txBitCnt <= txBitCnt + 4'h1;
          end
        end
        TX_BREAK: if (bitTick) begin
          if (txBitCnt == BREAK_LAST) begin
            txBitCnt <= 4'h0;
            if (!brkCtrl) begin
              txState   <= TX_STOP; // R17
              txPin     <= 1'b1;
              txStopCnt <= 1'b0;
            end
          end else begin
            txBitCnt <= txBitCnt + 4'h1; // R16
          end
        end
        TX_STOP: if (bitTick) begin
          if (twoStop && !txStopCnt) txStopCnt <= 1'b1; // R4
          else txState <= TX_IDLE; // R6
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) txIdleFlag <= 1'b1;
    else if (!uartOn || txFrameDone || (!txRun && txState != TX_IDLE))
      txIdleFlag <= 1'b1; // R14 R26 R8
    else if (dataWr && statusSeenReg && txEmptyFlag)
      txIdleFlag <= 1'b0; // R11
  end

  // Receiver
  uft_rx_state_t rxState;
  uft_word_t rxMem [2];
  logic rxSync1, rxSync2, sampA, sampB, vote, noisy, rxNoise;
  logic [3:0] rxPhase, rxBitCnt;
  logic [8:0] rxShift, rxWord;
  logic rxPush, rxPop, rxWrPtr, rxRdPtr, rxAvail, rxIdle;
  logic [1:0] rxCnt;
  logic parFlag, noiseFlag, framingFlag, overrunFlag;

  assign vote    = (sampA & sampB) | (sampA & rxSync2) |
                   (sampB & rxSync2); // R19
  assign noisy   = !(sampA == sampB && sampB == rxSync2);
  assign rxWord  = nine ? rxShift : {1'b0, rxShift[8:1]};
  assign rxPush  = rxRun && sampleTick && rxState == RX_STOP &&
                   rxPhase == VOTE_C;
  assign rxPop   = dataRd && rxAvail;
  assign rxAvail = rxCnt != 2'h0;
  assign rxIdle  = rxState == RX_IDLE || rxState == RX_WAIT;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSync1 <= 1'b1;
      rxSync2 <= 1'b1;
    end else begin
      rxSync1 <= rxPin;
      rxSync2 <= rxSync1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState  <= RX_IDLE;
      rxPhase  <= 4'h0;
      rxBitCnt <= 4'h0;
      rxShift  <= 9'h000;
      rxNoise  <= 1'b0;
      sampA    <= 1'b1;
      sampB    <= 1'b1;
    end else if (!rxRun) begin
      rxState <= RX_IDLE;
    end else if (sampleTick) begin
      rxPhase <= rxPhase + 4'h1;
      if (rxPhase == VOTE_A) sampA <= rxSync2;
      if (rxPhase == VOTE_B) sampB <= rxSync2;
      unique case (rxState)
        RX_IDLE: begin
          rxPhase <= 4'h0;
          rxNoise <= 1'b0;
          if (!rxSync2) rxState <= RX_START; // R23
        end
        RX_START: begin
          if (rxPhase == VOTE_C && vote) rxState <= RX_IDLE;
          if (rxPhase == VOTE_C) rxNoise <= noisy;
          if (rxPhase == LAST_PHASE) begin
            rxState  <= RX_DATA;
            rxBitCnt <= 4'h0;
          end
        end
        RX_DATA: begin
          if (rxPhase == VOTE_C) begin
            rxShift  <= {vote, rxShift[8:1]}; // R18
            rxBitCnt <= rxBitCnt + 4'h1;
            rxNoise  <= rxNoise | noisy;
          end
          if (rxPhase == LAST_PHASE && rxBitCnt == nBits)
            rxState <= RX_STOP;
        end
        RX_STOP: if (rxPhase == VOTE_C) begin
          rxState <= vote ? RX_IDLE : RX_WAIT; // R4
        end
        RX_WAIT: if (rxSync2) rxState <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCnt   <= 2'h0;
      rxWrPtr <= 1'b0;
      rxRdPtr <= 1'b0;
    end else if (!uartOn) begin
      rxCnt   <= 2'h0; // R26
      rxWrPtr <= 1'b0;
      rxRdPtr <= 1'b0;
    end else begin
      if (rxPush && rxCnt != FIFO_FULL) rxWrPtr <= !rxWrPtr; // R20
      if (rxPop) rxRdPtr <= !rxRdPtr; // R22
      if ((rxPush && rxCnt != FIFO_FULL) && !rxPop)
        rxCnt <= rxCnt + 2'h1; // R21
      else if (!(rxPush && rxCnt != FIFO_FULL) && rxPop)
        rxCnt <= rxCnt - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rxPush && rxCnt != FIFO_FULL)
      rxMem[rxWrPtr] <= rxWord; // R2 R20
  end

  // Error flags: a new event beats the acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      parFlag     <= 1'b0;
      noiseFlag   <= 1'b0;
      framingFlag <= 1'b0;
      overrunFlag <= 1'b0;
    end else if (!uartOn) begin
      parFlag     <= 1'b0; // R26
      noiseFlag   <= 1'b0;
      framingFlag <= 1'b0;
      overrunFlag <= 1'b0;
    end else begin
      if (dataRd && statusSeenReg) begin
        parFlag     <= 1'b0; // R22
        noiseFlag   <= 1'b0;
        framingFlag <= 1'b0;
        overrunFlag <= 1'b0;
      end
      if (rxPush && rxCnt == FIFO_FULL) overrunFlag <= 1'b1; // R20
      if (rxPush && rxCnt != FIFO_FULL) begin
        if (!vote) framingFlag <= 1'b1; // R27 R23
        if (rxNoise | noisy) noiseFlag <= 1'b1;
        if (parEn && frameWord(rxWord, nine, 1'b1, parOdd) != rxWord)
          parFlag <= 1'b1; // R29
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rxIrq <= 1'b0;
    else rxIrq <= ctrl2Reg[C2_RXIE] & rxPush; // R21
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdataReg <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_CTRL1: begin
          rdataReg <= ctrl1Reg;
          rdataReg[C1_RX8] <= rxAvail & rxMem[rxRdPtr].ninth; // R2
        end
        ADDR_CTRL2:  rdataReg <= ctrl2Reg;
        ADDR_STATUS: rdataReg <= {parFlag, noiseFlag, framingFlag,
                                  overrunFlag, rxIdle, rxAvail,
                                  txIdleFlag, txEmptyFlag};
        ADDR_DATA:   rdataReg <= rxAvail ? rxMem[rxRdPtr].data : 8'h00;
        ADDR_BAUD:   rdataReg <= baudReg;
        default:     rdataReg <= 8'h00;
      endcase
    end else begin
      rdataReg <= 8'h00;
    end
  end
  assign regRdata = rdataReg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_tx_rest_high: assert property ( // R25
    txState == TX_IDLE |-> txPin) else $error("tx pin low in idle");
  a_write_ignored: assert property ( // R10
    dataWr && !txEmptyFlag && uartOn && !txFromBuf |=>
      txBuf == $past(txBuf) && txBufFull)
    else $error("write accepted while buffer full");
  a_direct_load: assert property ( // R13
    txLoadDirect |=> txState == TX_START && txEmptyFlag && !txPin)
    else $error("idle write did not start frame");
  a_tx_abort: assert property ( // R8
    !txRun |-> !txPinOe ##1 txState == TX_IDLE && txPin)
    else $error("transmitter not reset on disable");
  a_abort_idle: assert property ( // R8
    !txRun && txState != TX_IDLE |=> txIdleFlag)
    else $error("idle flag not set on abort");
  a_lsb_first: assert property ( // R9
    txState == TX_START && bitTick && !brkMode && txRun |=>
      txPin == $past(txShift[0]))
    else $error("first data bit not lsb");
  a_break_zeros: assert property ( // R16
    $rose(txState == TX_BREAK) |-> !txPin [*8])
    else $error("break not held low");
  a_frame_idle: assert property ( // R14
    txFrameDone |=> txIdleFlag && txState == TX_IDLE)
    else $error("idle flag not set after frame");
  a_overrun_set: assert property ( // R20
    rxPush && rxCnt == FIFO_FULL && !rxPop |=>
      overrunFlag && rxCnt == FIFO_FULL)
    else $error("overrun not flagged");
  a_rx_avail: assert property ( // R21
    rxPush && rxCnt != FIFO_FULL |=> rxAvail)
    else $error("received word not available");
  a_off_state: assert property ( // R26
    !uartOn |=> txIdleFlag && txEmptyFlag && !rxAvail && !overrunFlag)
    else $error("off state not applied");
endmodule

// ### uft_peer.sv
`timescale 1ns/1ns
module uft_peer (
  // Clock
  input  wire logic clk,
  // Serial line
  input  wire logic txLine,
  output logic      rxLine
);
  initial rxLine = 1'b1;

  // Bits go out LSB first, one bit every 16 clocks
  task automatic send(input logic [31:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxLine <= bits[i];
      repeat (16) @(posedge clk);
    end
    rxLine <= 1'b1;
    @(posedge clk);
  endtask

  // Samples mid-bit from the falling start edge
  task automatic grab(input int n, input int bc,
                      output logic [31:0] bits, output bit ok);
    int w;
    w = 0;
    bits = '0;
    while (txLine !== 1'b0 && w < 4000) begin
      @(posedge clk);
      w++;
    end
    ok = (w < 4000);
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txLine;
      repeat (bc) @(posedge clk);
    end
  endtask
endmodule

// ### uft_pkg.sv
package uft_pkg;
  // Register offsets
  localparam logic [2:0] ADDR_CTRL1  = 3'h0;
  localparam logic [2:0] ADDR_CTRL2  = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_DATA   = 3'h3;
  localparam logic [2:0] ADDR_BAUD   = 3'h4;
  // ctrl_reg_one fields
  localparam int C1_ON      = 7;
  localparam int C1_NINE    = 6;
  localparam int C1_PAREN   = 5;
  localparam int C1_ODD     = 4;
  localparam int C1_TWOSTOP = 3;
  localparam int C1_RX8     = 1;
  localparam int C1_TX8     = 0;
  // ctrl_reg_two fields
  localparam int C2_TXEN = 7;
  localparam int C2_RXEN = 6;
  localparam int C2_HS   = 5;
  localparam int C2_BRK  = 4;
  localparam int C2_RXIE = 3;
  localparam int C2_TXIE = 0;
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST  = 8'h00;
  // Timing counts
  localparam logic [1:0] LOW_PRESCALE = 2'h3;
  localparam logic [3:0] LAST_PHASE   = 4'hf;
  localparam logic [3:0] VOTE_A       = 4'h7;
  localparam logic [3:0] VOTE_B       = 4'h8;
  localparam logic [3:0] VOTE_C       = 4'h9;
  localparam logic [3:0] BREAK_LAST   = 4'hc;
  localparam logic [3:0] BITS_EIGHT   = 4'h8;
  localparam logic [3:0] BITS_NINE    = 4'h9;
  localparam logic [1:0] FIFO_FULL    = 2'h2;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_BREAK, TX_STOP
  } uft_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAIT
  } uft_rx_state_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } uft_word_t;
endpackage
